// File: hdl/dma_request_grant_handshake.sv
`timescale 1ns/1ps
`default_nettype none
module dma_request_grant_handshake (
	input  wire logic                                 aclk,
	input  wire logic                                 aresetn,
	// axi4-lite slave
	input  wire logic [7:0]                           s_axi_awaddr,
	input  wire logic                                 s_axi_awvalid,
	output logic                                      s_axi_awready,
	input  wire logic [31:0]                          s_axi_wdata,
	input  wire logic [3:0]                           s_axi_wstrb,
	input  wire logic                                 s_axi_wvalid,
	output logic                                      s_axi_wready,
	output logic [1:0]                                s_axi_bresp,
	output logic                                      s_axi_bvalid,
	input  wire logic                                 s_axi_bready,
	input  wire logic [7:0]                           s_axi_araddr,
	input  wire logic                                 s_axi_arvalid,
	output logic                                      s_axi_arready,
	output logic [31:0]                               s_axi_rdata,
	output logic [1:0]                                s_axi_rresp,
	output logic                                      s_axi_rvalid,
	input  wire logic                                 s_axi_rready,
	// peripheral side
	input  wire logic [dma_hs_pkg::NUM_CH-1:0]        dma_request_n,
	output logic [dma_hs_pkg::NUM_CH-1:0]             dma_grant_n,
	output dma_hs_pkg::ext_bus_t                      ext_bus,
	input  wire logic                                 ack,
	input  wire logic [dma_hs_pkg::DATA_W-1:0]        data_in
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		dma_hs_pkg::eng_state_t                           st;
		logic                                             ch;
		logic [2:0]                                       wcnt;
		logic                                             is_wr;
		logic [dma_hs_pkg::NUM_CH-1:0]                    grant_n;
		dma_hs_pkg::ext_bus_t                             bus;
		dma_hs_pkg::chan_cfg_t [dma_hs_pkg::NUM_CH-1:0]   cfg;
		logic [dma_hs_pkg::NUM_CH-1:0][31:0]              caddr;
		logic [dma_hs_pkg::NUM_CH-1:0][15:0]              ccount;
		logic [31:0]                                      rd_data;
		logic                                             rd_valid;
		logic                                             awready;
		logic                                             wready;
		logic [7:0]                                       awaddr;
		logic [31:0]                                      wdata;
		logic [3:0]                                       wstrb;
		logic                                             bvalid;
		logic [1:0]                                       bresp;
		logic                                             arready;
		logic                                             rvalid;
		logic [31:0]                                      rdata;
		logic [1:0]                                       rresp;
	} state_t;

	state_t                        s;
	state_t                        next_s;
	logic [dma_hs_pkg::NUM_CH-1:0] elig;
	logic                          buf_push;
	logic                          buf_pop;
	logic                          buf_in_ready;
	logic                          buf_out_valid;
	logic [31:0]                   buf_out_data;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// ****************************************
	// write data buffer
	// ****************************************
	two_entry_buffer #(
		.W (32)
	) u_wbuf (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.in_data   (s.wdata),
		.in_valid  (buf_push),
		.in_ready  (buf_in_ready),
		.out_data  (buf_out_data),
		.out_valid (buf_out_valid),
		.out_ready (buf_pop)
	);

	// ****************************************
	// per-channel start condition
	// ****************************************
	for (genvar i = 0; i < dma_hs_pkg::NUM_CH; i++) begin : g_elig
		assign elig[i] = s.cfg[i].en && (s.ccount[i] != 16'h0000)
			&& !dma_request_n[i]
			&& (s.cfg[i].dir ? buf_out_valid : !s.rd_valid);
	end

	// ****************************************
	// next state
	// ****************************************
	always_comb begin
		dma_hs_pkg::chan_cfg_t cc;
		logic                  c;
		logic                  wch;
		cc       = s.cfg[s.ch];
		c        = 1'b0;
		wch      = s.awaddr[dma_hs_pkg::CH_SEL_BIT];
		next_s   = s;
		buf_push = 1'b0;
		buf_pop  = 1'b0;

		// axi read channel; a read of the data register clears rd_valid
		if (s.arready && s_axi_arvalid) begin
			next_s.arready = 1'b0;
			next_s.rvalid  = 1'b1;
			next_s.rresp   = dma_hs_pkg::RESP_OKAY;
			next_s.rdata   = 32'h0000_0000;
			if (s_axi_araddr[7:5] == dma_hs_pkg::CH_BLOCK) begin
				case (s_axi_araddr[3:0])
					dma_hs_pkg::OFF_CFG: begin
						next_s.rdata = {20'h00000, s.cfg[s_axi_araddr[dma_hs_pkg::CH_SEL_BIT]]};
					end
					dma_hs_pkg::OFF_ADDR: begin
						next_s.rdata = s.caddr[s_axi_araddr[dma_hs_pkg::CH_SEL_BIT]];
					end
					dma_hs_pkg::OFF_COUNT: begin
						next_s.rdata = {16'h0000, s.ccount[s_axi_araddr[dma_hs_pkg::CH_SEL_BIT]]};
					end
					default: begin
						next_s.rresp = dma_hs_pkg::RESP_DECERR;
					end
				endcase
			end else if (s_axi_araddr == dma_hs_pkg::OFF_DATA_RD) begin
				next_s.rdata    = s.rd_data;
				next_s.rd_valid = 1'b0;
			end else if (s_axi_araddr == dma_hs_pkg::OFF_STATUS) begin
				next_s.rdata = {29'h0, s.rd_valid, buf_out_valid, s.st != dma_hs_pkg::ST_IDLE};
			end else begin
				next_s.rresp = dma_hs_pkg::RESP_DECERR;
			end
		end
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid  = 1'b0;
			next_s.arready = 1'b1;
		end

		// transfer engine
		case (s.st)
			dma_hs_pkg::ST_IDLE: begin
				if (|elig) begin
					c                = elig[0] ? 1'b0 : 1'b1;
					cc               = s.cfg[c];
					next_s.ch        = c;
					next_s.is_wr     = cc.dir;
					next_s.wcnt      = cc.wait_states;
					next_s.bus.addr  = s.caddr[c];
					next_s.bus.ms_n  = ~cc.ms_sel;
					if (cc.mode != dma_hs_pkg::MODE_PACED_MASTER) begin
						next_s.grant_n[c] = 1'b0;
					end
					if (cc.mode != dma_hs_pkg::MODE_HANDSHAKE) begin
						// ext-handshake strobe falls on the same edge as the grant; paced-master strobe falls with no grant
						next_s.bus.wr_n = !cc.dir;
						next_s.bus.rd_n = cc.dir;
						next_s.bus.sw_n = !(cc.dir && cc.mode == dma_hs_pkg::MODE_EXT_HANDSHAKE);
					end
					if (cc.dir) begin
						next_s.bus.dout = buf_out_data;
						next_s.bus.doe  = 1'b1;
						buf_pop         = 1'b1;
					end
					next_s.st = dma_hs_pkg::ST_ACTIVE;
				end
			end
			dma_hs_pkg::ST_ACTIVE: begin
				if (s.wcnt != 3'h0) begin
					next_s.wcnt = s.wcnt - 3'h1;
				end else if (cc.mode != dma_hs_pkg::MODE_HANDSHAKE && !ack) begin
					next_s.st = dma_hs_pkg::ST_ACTIVE;
				end else if (!dma_request_n[s.ch]) begin
					next_s.st = dma_hs_pkg::ST_ACTIVE;
				end else if (s.is_wr) begin
					next_s.bus.wr_n = 1'b1;
					next_s.bus.sw_n = 1'b1;
					next_s.st       = dma_hs_pkg::ST_STROBE_UP;
				end else begin
					next_s.rd_data    = data_in;
					next_s.rd_valid   = 1'b1;
					next_s.bus.rd_n   = 1'b1;
					next_s.grant_n[s.ch] = 1'b1;
					next_s.st         = dma_hs_pkg::ST_GRANT_UP;
				end
			end
			dma_hs_pkg::ST_STROBE_UP: begin
				next_s.grant_n[s.ch] = 1'b1;
				next_s.st            = dma_hs_pkg::ST_GRANT_UP;
			end
			dma_hs_pkg::ST_GRANT_UP: begin
				// selects and data drive dropped only once the grant is high; address is kept
				next_s.bus.ms_n      = dma_hs_pkg::BUS_IDLE.ms_n;
				next_s.bus.doe       = 1'b0;
				next_s.caddr[s.ch]   = s.caddr[s.ch] + 32'h0000_0001;
				next_s.ccount[s.ch]  = s.ccount[s.ch] - 16'h0001;
				next_s.st = cc.hold_idle ? dma_hs_pkg::ST_GAP : dma_hs_pkg::ST_IDLE;
			end
			dma_hs_pkg::ST_GAP: begin
				next_s.st = dma_hs_pkg::ST_IDLE;
			end
			default: begin
				next_s.st = dma_hs_pkg::ST_IDLE;
			end
		endcase

		// axi write channel; software writes win over engine updates
		if (s.awready && s_axi_awvalid) begin
			next_s.awready = 1'b0;
			next_s.awaddr  = s_axi_awaddr;
		end
		if (s.wready && s_axi_wvalid) begin
			next_s.wready = 1'b0;
			next_s.wdata  = s_axi_wdata;
			next_s.wstrb  = s_axi_wstrb;
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid  = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready  = 1'b1;
		end
		if (!s.awready && !s.wready && !s.bvalid) begin
			next_s.bresp  = dma_hs_pkg::RESP_OKAY;
			next_s.bvalid = 1'b1;
			if (s.awaddr[7:5] == dma_hs_pkg::CH_BLOCK) begin
				case (s.awaddr[3:0])
					dma_hs_pkg::OFF_CFG: begin
						next_s.cfg[wch] = dma_hs_pkg::chan_cfg_t'(
							12'(merge({20'h00000, s.cfg[wch]}, s.wdata, s.wstrb)));
					end
					dma_hs_pkg::OFF_ADDR: begin
						next_s.caddr[wch] = merge(s.caddr[wch], s.wdata, s.wstrb);
					end
					dma_hs_pkg::OFF_COUNT: begin
						next_s.ccount[wch] = 16'(merge({16'h0000, s.ccount[wch]}, s.wdata,
							s.wstrb));
					end
					default: begin
						next_s.bresp = dma_hs_pkg::RESP_DECERR;
					end
				endcase
			end else if (s.awaddr == dma_hs_pkg::OFF_DATA_WR) begin
				// stalls the response while the buffer is full
				buf_push      = 1'b1;
				next_s.bvalid = buf_in_ready;
			end else begin
				next_s.bresp = dma_hs_pkg::RESP_DECERR;
			end
		end
	end

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s         <= '0;
			s.st      <= dma_hs_pkg::ST_IDLE;
			s.bus     <= dma_hs_pkg::BUS_IDLE;
			s.grant_n <= dma_hs_pkg::GRANT_IDLE;
			s.cfg     <= {dma_hs_pkg::NUM_CH{dma_hs_pkg::CFG_RESET}};
			s.awready <= 1'b1;
			s.wready  <= 1'b1;
			s.arready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready  = s.wready;
	assign s_axi_bresp   = s.bresp;
	assign s_axi_bvalid  = s.bvalid;
	assign s_axi_arready = s.arready;
	assign s_axi_rdata   = s.rdata;
	assign s_axi_rresp   = s.rresp;
	assign s_axi_rvalid  = s.rvalid;
	assign dma_grant_n   = s.grant_n;
	assign ext_bus       = s.bus;

endmodule // dma_request_grant_handshake
`default_nettype wire

// File: hdl/dma_hs_pkg.sv
package dma_hs_pkg;

	localparam int NUM_CH      = 2;
	localparam int ADDR_W      = 32;
	localparam int DATA_W      = 32;
	localparam int CH_SEL_BIT  = 4;

	// channel registers, relative to the channel block
	localparam logic [3:0] OFF_CFG   = 4'h0;
	localparam logic [3:0] OFF_ADDR  = 4'h4;
	localparam logic [3:0] OFF_COUNT = 4'h8;
	localparam logic [2:0] CH_BLOCK  = 3'h0;
	// global registers
	localparam logic [7:0] OFF_DATA_WR = 8'h20;
	localparam logic [7:0] OFF_DATA_RD = 8'h24;
	localparam logic [7:0] OFF_STATUS  = 8'h28;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		MODE_HANDSHAKE,
		MODE_EXT_HANDSHAKE,
		MODE_PACED_MASTER
	} hs_mode_t;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ACTIVE,
		ST_STROBE_UP,
		ST_GRANT_UP,
		ST_GAP
	} eng_state_t;

	typedef struct packed {
		logic [3:0] ms_sel;
		logic       hold_idle;
		logic [2:0] wait_states;
		hs_mode_t   mode;
		logic       dir;
		logic       en;
	} chan_cfg_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [3:0]        ms_n;
		logic              rd_n;
		logic              wr_n;
		logic              sw_n;
		logic              page;
		logic [DATA_W-1:0] dout;
		logic              doe;
	} ext_bus_t;

	localparam chan_cfg_t CFG_RESET = '0;
	localparam ext_bus_t BUS_IDLE = '{addr: 32'h0000_0000, ms_n: 4'hF, rd_n: 1'b1,
		wr_n: 1'b1, sw_n: 1'b1, page: 1'b0, dout: 32'h0000_0000, doe: 1'b0};
	localparam logic [NUM_CH-1:0] GRANT_IDLE = 2'h3;

endpackage

// File: hdl/two_entry_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
	parameter int W = 32
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic [W-1:0] in_data,
	input  wire logic         in_valid,
	output logic              in_ready,
	output logic [W-1:0]      out_data,
	output logic              out_valid,
	input  wire logic         out_ready
);

	typedef struct packed {
		logic [W-1:0] d0;
		logic [W-1:0] d1;
		logic [1:0]   cnt;
	} buf_state_t;

	buf_state_t s;
	buf_state_t next_s;

	assign in_ready  = (s.cnt != 2'h2);
	assign out_valid = (s.cnt != 2'h0);
	assign out_data  = s.d0;

	always_comb begin
		next_s = s;
		if (out_valid && out_ready) begin
			next_s.d0  = s.d1;
			next_s.cnt = s.cnt - 2'h1;
		end
		if (in_valid && in_ready) begin
			if (next_s.cnt == 2'h0) begin
				next_s.d0 = in_data;
			end else begin
				next_s.d1 = in_data;
			end
			next_s.cnt = next_s.cnt + 2'h1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

endmodule // two_entry_buffer
`default_nettype wire

// File: verif/dma_request_grant_handshake_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// handshake checker
// ********************************
module dma_request_grant_handshake_asserts (
	input wire logic                 aclk,
	input wire logic                 aresetn,
	input wire logic                 s_axi_arvalid,
	input wire logic                 s_axi_arready,
	input wire logic                 s_axi_rvalid,
	input wire logic [1:0]           dma_request_n,
	input wire logic [1:0]           dma_grant_n,
	input wire dma_hs_pkg::ext_bus_t ext_bus
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	logic busy_req;
	assign busy_req = ((~dma_grant_n) & ~dma_request_n) != 2'h0;
	sequence s_wr_up;
		$rose(ext_bus.wr_n) && !(&dma_grant_n);
	endsequence
	sequence s_grant_up;
		$rose(&dma_grant_n);
	endsequence
	a_grant_req0: assert property ($fell(dma_grant_n[0]) |-> !$past(dma_request_n[0]))
		else $error("grant 0 without request");
	a_grant_req1: assert property ($fell(dma_grant_n[1]) |-> !$past(dma_request_n[1]))
		else $error("grant 1 without request");
	a_one_grant: assert property (dma_grant_n != 2'h0)
		else $error("two grants at once");
	a_wr_hold: assert property (busy_req && !ext_bus.wr_n |=> !ext_bus.wr_n)
		else $error("write ended under hold-off");
	a_rd_stretch: assert property (busy_req && !ext_bus.rd_n |=> !(&dma_grant_n))
		else $error("read grant not stretched");
	a_wr_first: assert property (s_wr_up |=> s_grant_up)
		else $error("grant did not follow write strobe");
	a_wr_low: assert property ($fell(ext_bus.wr_n) && !(&dma_grant_n) |-> $fell(&dma_grant_n))
		else $error("write strobe late");
	a_rd_rise: assert property ($rose(ext_bus.rd_n) && $past(dma_grant_n) != 2'h3 |-> &dma_grant_n)
		else $error("read strobe and grant split");
	a_sel_held: assert property (s_grant_up |-> $stable(ext_bus.addr) && $stable(ext_bus.ms_n))
		else $error("address moved before grant release");
	a_sw_with_wr: assert property (!ext_bus.sw_n |-> !ext_bus.wr_n && !(&dma_grant_n))
		else $error("sync write select alone");
	a_rvalid_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule // dma_request_grant_handshake_asserts
bind dma_request_grant_handshake dma_request_grant_handshake_asserts mon (
	.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .dma_request_n,
	.dma_grant_n, .ext_bus);
`default_nettype wire

// File: verif/dma_peer.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// peripheral model
// ********************************
module dma_peer (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	input  wire logic [1:0]           go,
	input  wire logic [3:0]           hold,
	input  wire logic                 slow,
	input  wire logic [1:0]           dma_grant_n,
	input  wire dma_hs_pkg::ext_bus_t ext_bus,
	output logic [1:0]                dma_request_n,
	output logic                      ack,
	output logic [31:0]               data_in
);
	logic [1:0][7:0] cnt;
	logic [1:0][3:0] hc;
	logic [2:0]      ac;
	logic [31:0]     last;
	logic            strobe;
	logic            idle;
	assign strobe = !(ext_bus.rd_n && ext_bus.wr_n);
	assign idle = &dma_grant_n && !strobe && ext_bus.ms_n == 4'hF;
	// slow mode keeps ack low two access cycles
	assign ack = !slow || ac >= 3'h2;
	// released bus shows the inverse of the last word
	assign data_in = ext_bus.rd_n ? ~last : {16'hC3C3, ext_bus.addr[15:0]};
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dma_request_n <= 2'h3;
			cnt <= '0;
			hc <= '0;
			ac <= 3'h0;
			last <= 32'h0;
		end else begin
			ac <= (strobe || !(&dma_grant_n)) ? ac + {2'h0, ac != 3'h7} : 3'h0;
			if (!ext_bus.rd_n) last <= data_in;
			for (int c = 0; c < 2; c++) begin
				if (!dma_request_n[c] && (!dma_grant_n[c] || (&dma_grant_n && strobe))) begin
					if (hc[c] >= hold) begin
						dma_request_n[c] <= 1'b1;
						hc[c] <= 4'h0;
					end else begin
						hc[c] <= hc[c] + 4'h1;
					end
					cnt[c] <= cnt[c] + {7'h0, go[c]};
				end else if (dma_request_n[c] && cnt[c] != 8'h0 && idle) begin
					dma_request_n[c] <= 1'b0;
					cnt[c] <= cnt[c] + {7'h0, go[c]} - 8'h1;
				end else begin
					cnt[c] <= cnt[c] + {7'h0, go[c]};
				end
			end
		end
	end
endmodule // dma_peer
`default_nettype wire

// File: verif/dma_request_grant_handshake_test.sv
`timescale 1ns/1ps
`default_nettype none
// ********************************
// testbench
// ********************************
module dma_request_grant_handshake_test;
	logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic        s_axi_rready, ack, slow;
	logic [7:0]  s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, data_in, v;
	logic [3:0]  s_axi_wstrb, hold;
	logic [1:0]  s_axi_bresp, s_axi_rresp, dma_request_n, dma_grant_n, go, r, g;
	dma_hs_pkg::ext_bus_t ext_bus;
	int          bad_count, cmp_count, cyc, w0, w1;
	dma_request_grant_handshake uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .dma_request_n, .dma_grant_n,
		.ext_bus, .ack, .data_in);
	dma_peer peer (.aclk, .aresetn, .go, .hold, .slow, .dma_grant_n, .ext_bus, .dma_request_n,
		.ack, .data_in);
	task automatic summarize();
		if (bad_count == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		r = s_axi_bresp;
	endtask
	task automatic rd(input logic [7:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		v = s_axi_rdata;
		r = s_axi_rresp;
	endtask
	task automatic pulse(input logic [3:0] ch, input int n);
		go[ch] <= 1'b1;
		repeat (n) @(posedge aclk);
		go[ch] <= 1'b0;
	endtask
	// one transfer; w counts cycles of grant or strobe low
	task automatic xfer(input logic [3:0] ch, input logic [11:0] cfg, input logic [3:0] h,
		output int w);
		if (cfg[1]) wr(dma_hs_pkg::OFF_DATA_WR, 32'h1357_9BDF);
		wr({ch, dma_hs_pkg::OFF_ADDR}, 32'h40);
		wr({ch, dma_hs_pkg::OFF_COUNT}, 32'h1);
		wr({ch, dma_hs_pkg::OFF_CFG}, {20'h0, cfg});
		hold <= h;
		pulse(ch, 1);
		w = 0;
		g = 2'h0;
		repeat (60) begin
			@(posedge aclk);
			g = g | ~dma_grant_n;
			if (!(ext_bus.rd_n && ext_bus.wr_n) || !dma_grant_n[ch]) begin
				if (w == 0) begin
					chk(ext_bus.addr, 32'h40, "address");
					chk({28'h0, ext_bus.ms_n}, {28'h0, ~cfg[11:8]}, "select");
					if (cfg[1]) chk(ext_bus.dout, 32'h1357_9BDF, "write word");
				end
				w++;
			end
		end
	endtask
	task automatic t_regs();
		rd(dma_hs_pkg::OFF_STATUS);
		chk(v, 32'h0, "status reset");
		rd({4'h0, dma_hs_pkg::OFF_CFG});
		chk(v, 32'h0, "cfg reset");
		rd(8'h30);
		chk(v, 32'h0, "unmapped data");
		chk({30'h0, r}, {30'h0, dma_hs_pkg::RESP_DECERR}, "unmapped read");
		wr(8'h30, 32'hFFFF_FFFF);
		chk({30'h0, r}, {30'h0, dma_hs_pkg::RESP_DECERR}, "unmapped write");
	endtask
	task automatic t_xfers();
		xfer(4'h0, 12'h127, 4'h0, w0);
		xfer(4'h0, 12'h157, 4'h0, w1);
		chk(32'(w1 - w0), 32'h3, "wait stretch");
		chk({30'h0, g}, 32'h1, "ext grant");
		xfer(4'h0, 12'h205, 4'h0, w0);
		rd(dma_hs_pkg::OFF_DATA_RD);
		chk(v, 32'hC3C3_0040, "read word");
		xfer(4'h0, 12'h205, 4'h2, w1);
		rd(dma_hs_pkg::OFF_DATA_RD);
		chk(32'(w1 - w0), 32'h2, "read stretch");
		slow <= 1'b1;
		xfer(4'h0, 12'h409, 4'h0, w0);
		slow <= 1'b0;
		chk({30'h0, g}, 32'h0, "paced grant");
		rd(dma_hs_pkg::OFF_DATA_RD);
		chk(v, 32'hC3C3_0040, "paced word");
		wr({4'h0, dma_hs_pkg::OFF_CFG}, 32'h0);
		xfer(4'h1, 12'h803, 4'h0, w0);
		chk({30'h0, g}, 32'h2, "own grant");
	endtask
	task automatic t_stall();
		wr({4'h0, dma_hs_pkg::OFF_ADDR}, 32'h40);
		wr({4'h0, dma_hs_pkg::OFF_COUNT}, 32'h3);
		wr({4'h0, dma_hs_pkg::OFF_CFG}, 32'h107);
		wr(dma_hs_pkg::OFF_DATA_WR, 32'h1);
		wr(dma_hs_pkg::OFF_DATA_WR, 32'h2);
		repeat (20) @(posedge aclk);
		rd({4'h0, dma_hs_pkg::OFF_COUNT});
		chk(v, 32'h3, "idle without request");
		fork
			wr(dma_hs_pkg::OFF_DATA_WR, 32'h3);
			begin
				repeat (10) @(posedge aclk);
				chk({31'h0, s_axi_bvalid}, 32'h0, "full buffer stall");
				pulse(4'h0, 3);
			end
		join
		repeat (100) @(posedge aclk);
		rd({4'h0, dma_hs_pkg::OFF_COUNT});
		chk(v, 32'h0, "count drained");
		rd(dma_hs_pkg::OFF_STATUS);
		chk(v, 32'h0, "status idle");
	endtask
	initial begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			summarize();
		end
	end
	initial begin
		// response readies stay high so back-to-back calls never toggle them
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h05;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		{aresetn, slow, go, hold} = 8'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		t_regs();
		t_xfers();
		t_stall();
		summarize();
	end
endmodule // dma_request_grant_handshake_test
`default_nettype wire
